// *** core/sbad_decoder.v ***
// Purpose: System bus address decoder with one fixed map
// Assumes: One master request per cycle; select outputs registered one cycle later
// Notes: Variant sizes and the external bus presence are parameters
`include "sbad_consts.vh"

module sbad_decoder #(
	parameter [31:0] SRAM_SIZE = `SBAD_SRAM_64K,
	parameter [31:0] FLASH_SIZE = `SBAD_FLASH_512K,
	parameter HAS_EXT_BUS = 1
) (
	clock,
	rst,
	req_valid,
	req_addr,
	req_ready,
	sel,
	sel_offset,
	csel,
	bsel,
	asel,
	resp_error,
	resp_valid
);
	input wire clock;
	input wire rst;
	input wire req_valid;
	input wire [31:0] req_addr;
	output wire req_ready;
	output reg [`SBAD_SEL_W-1:0] sel;
	output reg [31:0] sel_offset;
	output reg [`SBAD_CSEL_W-1:0] csel;
	output reg [`SBAD_BSEL_W-1:0] bsel;
	output reg [`SBAD_ASEL_W-1:0] asel;
	output reg resp_error;
	output reg resp_valid;

	localparam EXT = (HAS_EXT_BUS != 0) ? 1'b1 : 1'b0;

	// ==========================================
	// Top level windows
	// No remap control exists at all, so the map cannot change in boot
	wire [`SBAD_SEL_W-1:0] hit;
	// Whole 32-bit address compared, no translation stage
	sbad_window #(.BASE(`SBAD_SRAM_BASE), .SIZE(SRAM_SIZE)) u_sram (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_SRAM]));
	sbad_window #(.BASE(`SBAD_FLASH_BASE), .SIZE(FLASH_SIZE)) u_flash (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_FLASH]));
	sbad_window #(.BASE(`SBAD_SAU_BASE), .SIZE(`SBAD_SAU_SIZE)) u_sau (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_SAU]));
	sbad_window #(.BASE(`SBAD_HSRAM_BASE), .SIZE(`SBAD_HSRAM_SIZE)) u_hsram (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_HSRAM]));
	sbad_window #(.BASE(`SBAD_XCS0_BASE), .SIZE(`SBAD_XCS_SIZE)) u_xcs0 (
		.addr(req_addr), .enable(EXT), .hit(hit[`SBAD_SEL_XCS0]));
	sbad_window #(.BASE(`SBAD_XCS2_BASE), .SIZE(`SBAD_XCS_SIZE)) u_xcs2 (
		.addr(req_addr), .enable(EXT), .hit(hit[`SBAD_SEL_XCS2]));
	sbad_window #(.BASE(`SBAD_XCS3_BASE), .SIZE(`SBAD_XCS_SIZE)) u_xcs3 (
		.addr(req_addr), .enable(EXT), .hit(hit[`SBAD_SEL_XCS3]));
	sbad_window #(.BASE(`SBAD_XCS1_BASE), .SIZE(`SBAD_XCS1_SIZE)) u_xcs1 (
		.addr(req_addr), .enable(EXT), .hit(hit[`SBAD_SEL_XCS1]));
	sbad_window #(.BASE(`SBAD_BRC_BASE), .SIZE(`SBAD_BRIDGE_SIZE)) u_brc (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_BRC]));
	sbad_window #(.BASE(`SBAD_BRB_BASE), .SIZE(`SBAD_BRIDGE_SIZE)) u_brb (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_BRB]));
	sbad_window #(.BASE(`SBAD_BRA_BASE), .SIZE(`SBAD_BRIDGE_SIZE)) u_bra (
		.addr(req_addr), .enable(1'b1), .hit(hit[`SBAD_SEL_BRA]));

	// ==========================================
	// Peripheral slots, indexed by 1 KB slot number within a bridge
	wire [15:0] poff;
	wire [`SBAD_SLOT_BITS-1:0] slot;
	assign poff = req_addr[15:0];
	assign slot = poff[15:10];

	function [`SBAD_SLOT_BITS-1:0] slot_of;
		input [15:0] off;
		begin
			slot_of = off[15:10];
		end
	endfunction

	reg [`SBAD_CSEL_W-1:0] c_next;
	reg [`SBAD_BSEL_W-1:0] b_next;
	reg [`SBAD_ASEL_W-1:0] a_next;
	always @* begin
		c_next = {`SBAD_CSEL_W{1'b0}};
		b_next = {`SBAD_BSEL_W{1'b0}};
		a_next = {`SBAD_ASEL_W{1'b0}};
		// Peripheral DMA owns a 4 KB slot, so any of its four sub-slots selects it
		c_next[0] = (poff < `SBAD_C_PDMA_SIZE);
		c_next[1] = (slot == slot_of(`SBAD_C_MEMORY_DMA));
		c_next[2] = (slot == slot_of(`SBAD_C_SER1));
		c_next[3] = (slot == slot_of(`SBAD_C_SPP0));
		c_next[4] = (slot == slot_of(`SBAD_C_CAN));
		c_next[5] = (slot == slot_of(`SBAD_C_TMR0));
		c_next[6] = (slot == slot_of(`SBAD_C_ADC));
		c_next[7] = (slot == slot_of(`SBAD_C_SER4));
		c_next[8] = (slot == slot_of(`SBAD_C_TWM2));
		c_next[9] = (slot == slot_of(`SBAD_C_TWS2));
		b_next[0] = (poff < `SBAD_B_USB);
		b_next[1] = (poff >= `SBAD_B_USB) && (poff < `SBAD_B_MTX);
		b_next[2] = (slot == slot_of(`SBAD_B_MTX));
		b_next[3] = (slot == slot_of(`SBAD_B_SAUC));
		b_next[4] = (slot == slot_of(`SBAD_B_SMC));
		b_next[5] = (slot == slot_of(`SBAD_B_SDR));
		b_next[6] = (slot == slot_of(`SBAD_B_MAC));
		a_next[0] = (slot == slot_of(`SBAD_A_INT));
		a_next[1] = (slot == slot_of(`SBAD_A_PWR));
		a_next[2] = (slot == slot_of(`SBAD_A_SYS));
	end

	// ==========================================
	// Resolve: only the owning bridge's slot vector passes
	wire [`SBAD_CSEL_W-1:0] csel_next;
	wire [`SBAD_BSEL_W-1:0] bsel_next;
	wire [`SBAD_ASEL_W-1:0] asel_next;
	assign csel_next = hit[`SBAD_SEL_BRC] ? c_next : {`SBAD_CSEL_W{1'b0}};
	assign bsel_next = hit[`SBAD_SEL_BRB] ? b_next : {`SBAD_BSEL_W{1'b0}};
	assign asel_next = hit[`SBAD_SEL_BRA] ? a_next : {`SBAD_ASEL_W{1'b0}};

	// A bridge hit with an empty slot is still an error; an empty peripheral slot
	// would otherwise hang the master waiting for a slave that does not exist
	wire bridge_hole;
	assign bridge_hole = (hit[`SBAD_SEL_BRC] && (c_next == {`SBAD_CSEL_W{1'b0}}))
		|| (hit[`SBAD_SEL_BRB] && (b_next == {`SBAD_BSEL_W{1'b0}}))
		|| (hit[`SBAD_SEL_BRA] && (a_next == {`SBAD_ASEL_W{1'b0}}));
	wire miss;
	assign miss = (hit == {`SBAD_SEL_W{1'b0}}) || bridge_hole;

	// Offset inside the chosen window; flash base maps to flash word zero
	reg [31:0] off_next;
	always @* begin
		off_next = req_addr;
		case (1'b1)
			hit[`SBAD_SEL_FLASH]: off_next = req_addr - `SBAD_FLASH_BASE;
			hit[`SBAD_SEL_SAU]: off_next = req_addr - `SBAD_SAU_BASE;
			hit[`SBAD_SEL_HSRAM]: off_next = req_addr - `SBAD_HSRAM_BASE;
			hit[`SBAD_SEL_XCS0]: off_next = req_addr - `SBAD_XCS0_BASE;
			hit[`SBAD_SEL_XCS2]: off_next = req_addr - `SBAD_XCS2_BASE;
			hit[`SBAD_SEL_XCS3]: off_next = req_addr - `SBAD_XCS3_BASE;
			hit[`SBAD_SEL_XCS1]: off_next = req_addr - `SBAD_XCS1_BASE;
			hit[`SBAD_SEL_BRC]: off_next = req_addr - `SBAD_BRC_BASE;
			hit[`SBAD_SEL_BRB]: off_next = req_addr - `SBAD_BRB_BASE;
			hit[`SBAD_SEL_BRA]: off_next = req_addr - `SBAD_BRA_BASE;
			default: off_next = req_addr;
		endcase
	end

	// ==========================================
	// Output registers; decoder never stalls
	assign req_ready = 1'b1;

	// Windows are disjoint by construction, so at most one select can be set
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sel <= {`SBAD_SEL_W{1'b0}};
			sel_offset <= 32'h0000_0000;
			csel <= {`SBAD_CSEL_W{1'b0}};
			bsel <= {`SBAD_BSEL_W{1'b0}};
			asel <= {`SBAD_ASEL_W{1'b0}};
			resp_error <= 1'b0;
			resp_valid <= 1'b0;
		end else begin
			resp_valid <= req_valid;
			resp_error <= req_valid && miss;
			sel <= (req_valid && !miss) ? hit : {`SBAD_SEL_W{1'b0}};
			sel_offset <= req_valid ? off_next : 32'h0000_0000;
			csel <= (req_valid && !miss) ? csel_next : {`SBAD_CSEL_W{1'b0}};
			bsel <= (req_valid && !miss) ? bsel_next : {`SBAD_BSEL_W{1'b0}};
			asel <= (req_valid && !miss) ? asel_next : {`SBAD_ASEL_W{1'b0}};
		end
	end
endmodule

// *** shared/sbad_consts.vh ***
// Purpose: Address map constants for the system bus address decoder
// Assumes: 32-bit byte addresses
// Notes: Sizes are in bytes; windows are naturally aligned to their size
`ifndef SBAD_CONSTS_VH
`define SBAD_CONSTS_VH

// ==========================================
// Region bases
`define SBAD_SRAM_BASE 32'h0000_0000
`define SBAD_FLASH_BASE 32'h8000_0000
`define SBAD_SAU_BASE 32'h9000_0000
`define SBAD_HSRAM_BASE 32'ha000_0000
`define SBAD_XCS0_BASE 32'hc000_0000
`define SBAD_XCS2_BASE 32'hc800_0000
`define SBAD_XCS3_BASE 32'hcc00_0000
`define SBAD_XCS1_BASE 32'hd000_0000
`define SBAD_BRC_BASE 32'hfffd_0000
`define SBAD_BRB_BASE 32'hfffe_0000
`define SBAD_BRA_BASE 32'hffff_0000

// ==========================================
// Region sizes
`define SBAD_SRAM_64K 32'h0001_0000
`define SBAD_SRAM_32K 32'h0000_8000
`define SBAD_FLASH_512K 32'h0008_0000
`define SBAD_FLASH_256K 32'h0004_0000
`define SBAD_FLASH_128K 32'h0002_0000
`define SBAD_SAU_SIZE 32'h0000_0400
`define SBAD_HSRAM_SIZE 32'h0000_1000
`define SBAD_XCS_SIZE 32'h0100_0000
`define SBAD_XCS1_SIZE 32'h0800_0000
`define SBAD_BRIDGE_SIZE 32'h0001_0000

// ==========================================
// Peripheral slot offsets inside a bridge window (low 16 bits)
`define SBAD_SLOT_SIZE 16'h0400
`define SBAD_SLOT_BITS 6
`define SBAD_C_PDMA 16'h0000
`define SBAD_C_PDMA_SIZE 16'h1000
`define SBAD_C_MEMORY_DMA 16'h1000
`define SBAD_C_SER1 16'h1400
`define SBAD_C_SPP0 16'h1800
`define SBAD_C_CAN 16'h1c00
`define SBAD_C_TMR0 16'h2000
`define SBAD_C_ADC 16'h2400
`define SBAD_C_SER4 16'h2800
`define SBAD_C_TWM2 16'h2c00
`define SBAD_C_TWS2 16'h3000
`define SBAD_B_FLC 16'h0000
`define SBAD_B_FLC_SIZE 16'h1000
`define SBAD_B_USB 16'h1000
`define SBAD_B_USB_SIZE 16'h1000
`define SBAD_B_MTX 16'h2000
`define SBAD_B_SAUC 16'h2400
`define SBAD_B_SMC 16'h2800
`define SBAD_B_SDR 16'h2c00
`define SBAD_B_MAC 16'h3000
`define SBAD_A_INT 16'h0000
`define SBAD_A_PWR 16'h0400
`define SBAD_A_SYS 16'h0800

// ==========================================
// Select vector bit positions
`define SBAD_SEL_W 11
`define SBAD_SEL_SRAM 0
`define SBAD_SEL_FLASH 1
`define SBAD_SEL_SAU 2
`define SBAD_SEL_HSRAM 3
`define SBAD_SEL_XCS0 4
`define SBAD_SEL_XCS2 5
`define SBAD_SEL_XCS3 6
`define SBAD_SEL_XCS1 7
`define SBAD_SEL_BRC 8
`define SBAD_SEL_BRB 9
`define SBAD_SEL_BRA 10
`define SBAD_CSEL_W 10
`define SBAD_BSEL_W 7
`define SBAD_ASEL_W 3

`endif

// *** core/sbad_window.v ***
// Purpose: One aligned address window match
// Assumes: SIZE is a power of two and BASE is aligned to SIZE
// Notes: Purely combinational; a disabled window never matches
module sbad_window #(
	parameter AW = 32,
	parameter [AW-1:0] BASE = {AW{1'b0}},
	parameter [AW-1:0] SIZE = {{(AW-1){1'b0}}, 1'b1}
) (
	addr,
	enable,
	hit
);
	input wire [AW-1:0] addr;
	input wire enable;
	output wire hit;

	// ==========================================
	// Match
	wire [AW-1:0] mask;
	assign mask = ~(SIZE - {{(AW-1){1'b0}}, 1'b1});
	assign hit = enable && ((addr & mask) == (BASE & mask));
endmodule

// *** testbench/sbad_checker.sv ***
// Purpose: Port checks for the address decoder
// Assumes: One registered answer cycle after each taken request
// Notes: Bound to every decoder instance
module sbad_checker #(
	parameter [31:0] SRAM_SIZE = 32'h0001_0000,
	parameter [31:0] FLASH_SIZE = 32'h0008_0000,
	parameter HAS_EXT_BUS = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	input wire logic req_ready,
	input wire logic [10:0] sel,
	input wire logic [31:0] sel_offset,
	input wire logic [9:0] csel,
	input wire logic [6:0] bsel,
	input wire logic [2:0] asel,
	input wire logic resp_error,
	input wire logic resp_valid
);
	logic [31:0] last_addr;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Keeps the taken address for checks on the answer cycle
	always_ff @(posedge clock) last_addr <= req_addr;
	// ==========================================
	// Properties
	property p_answer;
		req_valid |=> resp_valid && (resp_error == (sel == 11'h0));
	endproperty
	a_answer: assert property (p_answer) else $error("answer missing");
	property p_quiet;
		!req_valid |=> !resp_valid && sel == 11'h0 && {csel, bsel, asel} == 20'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("select without request");
	property p_onehot;
		$onehot0(sel) && $onehot0({csel, bsel, asel});
	endproperty
	a_onehot: assert property (p_onehot) else $error("several selects");
	property p_boot;
		req_valid && req_addr == 32'h8000_0000 |=> sel == 11'h002 && sel_offset == 32'h0;
	endproperty
	a_boot: assert property (p_boot) else $error("boot fetch misrouted");
	property p_sram;
		req_valid && req_addr < SRAM_SIZE |=> sel[0] && sel_offset == last_addr;
	endproperty
	a_sram: assert property (p_sram) else $error("sram decode");
	property p_flash;
		req_valid && (req_addr - 32'h8000_0000) < FLASH_SIZE |=> sel[1];
	endproperty
	a_flash: assert property (p_flash) else $error("flash decode");
	property p_gap;
		req_valid && req_addr >= SRAM_SIZE && req_addr < 32'h8000_0000 |=> resp_error;
	endproperty
	a_gap: assert property (p_gap) else $error("alias below flash");
	property p_ext;
		req_valid && req_addr[31:24] == 8'hc0 |=> sel[4] == (HAS_EXT_BUS != 0);
	endproperty
	a_ext: assert property (p_ext) else $error("external window");
	property p_bra;
		req_valid && req_addr[31:12] == 20'hffff0 && req_addr[11:10] != 2'b11
			|=> sel[10] && asel == (3'b001 << last_addr[11:10]);
	endproperty
	a_bra: assert property (p_bra) else $error("bridge a slot");
	property p_brc;
		req_valid && req_addr[31:12] == 20'hfffd1
			|=> sel[8] && csel == (10'h002 << last_addr[11:10]);
	endproperty
	a_brc: assert property (p_brc) else $error("bridge c slot");
	c_boot: cover property (req_valid && req_addr == 32'h8000_0000 ##1 resp_valid);
	c_err: cover property (resp_error);
	c_brc: cover property (sel[8] && csel[9]);
endmodule

// *** testbench/sbad_master_model.sv ***
// Purpose: Bus master issuing one address per cycle
// Assumes: Requests change at the falling edge
// Notes: A released address bus shows the inverse of its last value
module sbad_master_model (
	input wire logic clock,
	output logic req_valid,
	output logic [31:0] req_addr
);
	initial begin
		req_valid = 1'b0;
		req_addr = 32'h0;
	end
	task send(input logic [31:0] a);
		@(negedge clock);
		req_valid <= 1'b1;
		req_addr <= a;
	endtask
	task idle();
		@(negedge clock);
		req_valid <= 1'b0;
		req_addr <= ~req_addr;
	endtask
endmodule

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the address decoder
// Assumes: Full variant plus a small variant without external bus
// Notes: Bridge slots are walked by loops
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [31:0] a; logic [10:0] s; logic [31:0] o;} sbad_row_t;
	logic clock, rst, req_valid, rdy, err, vld, err2, vld2;
	logic [31:0] req_addr, off, a;
	logic [10:0] sel, sel2;
	logic [9:0] cs;
	logic [6:0] bs;
	logic [2:0] as;
	int num_errors = 0;
	int n_checks = 0;
	sbad_row_t rows [13] = '{
		'{32'h0000_0000, 11'h001, 32'h0}, '{32'h0000_fffc, 11'h001, 32'hfffc},
		'{32'h0001_0000, 11'h000, 32'h0001_0000}, '{32'h8007_fffc, 11'h002, 32'h7fffc},
		'{32'h8008_0000, 11'h000, 32'h8008_0000}, '{32'h9000_03fc, 11'h004, 32'h3fc},
		'{32'h9000_0400, 11'h000, 32'h9000_0400}, '{32'ha000_0ffc, 11'h008, 32'hffc},
		'{32'hc000_0010, 11'h010, 32'h10}, '{32'hc800_0000, 11'h020, 32'h0},
		'{32'hcc00_0004, 11'h040, 32'h4}, '{32'hd7ff_fffc, 11'h080, 32'h7ff_fffc},
		'{32'h4000_0000, 11'h000, 32'h4000_0000}};
	sbad_master_model u_mst (.clock(clock), .req_valid(req_valid), .req_addr(req_addr));
	sbad_decoder u_dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
		.req_ready(rdy), .sel(sel), .sel_offset(off), .csel(cs), .bsel(bs), .asel(as),
		.resp_error(err), .resp_valid(vld));
	sbad_decoder #(.SRAM_SIZE(32'h8000), .FLASH_SIZE(32'h2_0000), .HAS_EXT_BUS(0)) u_dut2 (
		.clock(clock), .rst(rst), .req_valid(req_valid), .req_addr(req_addr), .req_ready(),
		.sel(sel2), .sel_offset(), .csel(), .bsel(), .asel(), .resp_error(err2),
		.resp_valid(vld2));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task expect_resp(input logic [10:0] s, input logic [19:0] p, input logic [31:0] o);
		chk("valid", 32'h1, {31'h0, vld});
		chk("sel", {21'h0, s}, {21'h0, sel});
		chk("slot", {12'h0, p}, {12'h0, cs, bs, as});
		chk("error", {31'h0, s == 11'h0}, {31'h0, err});
		chk("offset", o, off);
		chk("ready", 32'h1, {31'h0, rdy});
	endtask
	task run(input logic [31:0] x, input logic [10:0] s, input logic [19:0] p);
		u_mst.send(x);
		u_mst.idle();
		// Bridge holes still report the offset inside the bridge window
		expect_resp(s, p, {16'h0, x[15:0]});
	endtask
	task run2(input logic [31:0] x, input logic [10:0] s);
		u_mst.send(x);
		u_mst.idle();
		chk("valid2", 32'h1, {31'h0, vld2});
		chk("sel2", {21'h0, s}, {21'h0, sel2});
		chk("error2", {31'h0, s == 11'h0}, {31'h0, err2});
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clock);
		num_errors++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		foreach (rows[i]) begin
			u_mst.send(rows[i].a);
			u_mst.idle();
			expect_resp(rows[i].s, 20'h0, rows[i].o);
		end
		for (int i = 0; i < 10; i++)
			run(32'hfffd_0000 + (i == 0 ? 0 : 32'h0c00 + 32'h400 * i), 11'h100,
				20'h1 << (10 + i));
		for (int i = 0; i < 7; i++)
			run(32'hfffe_0000 + (i == 0 ? 0 : i == 1 ? 32'h1000 : 32'h1800 + 32'h400 * i),
				11'h200, 20'h1 << (3 + i));
		for (int i = 0; i < 3; i++)
			run(32'hffff_0000 + 32'h400 * i, 11'h400, 20'h1 << i);
		run(32'hffff_0c00, 11'h000, 20'h0);
		// Back to back: the answer to the first shows while the second is taken
		u_mst.send(32'h8000_0004);
		u_mst.send(32'hfffd_3400);
		expect_resp(11'h002, 20'h0, 32'h4);
		u_mst.idle();
		expect_resp(11'h000, 20'h0, 32'h0000_3400);
		run2(32'hc000_0000, 11'h000);
		run2(32'hd000_0000, 11'h000);
		run2(32'h0000_8000, 11'h000);
		run2(32'h8002_0000, 11'h000);
		run2(32'h8001_fffc, 11'h002);
		u_mst.send(32'ha000_0000);
		u_mst.idle();
		rst = 1'b1;
		#1;
		chk("reset sel", 32'h0, {20'h0, sel, vld});
		repeat (16) @(negedge clock);
		rst = 1'b0;
		run(32'h8000_0000, 11'h002, 20'h0);
		wrap_up();
	end
endmodule
bind sbad_decoder sbad_checker #(.SRAM_SIZE(SRAM_SIZE), .FLASH_SIZE(FLASH_SIZE),
	.HAS_EXT_BUS(HAS_EXT_BUS)) u_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
	.req_addr(req_addr), .req_ready(req_ready), .sel(sel), .sel_offset(sel_offset),
	.csel(csel), .bsel(bsel), .asel(asel), .resp_error(resp_error), .resp_valid(resp_valid));
